//--- rtl/twecl_device.sv
// device end: instruction decode, array, write protect and program timer
//
// Function
// - chip select, lead bit, opcode, address
// - opcode 10 reads; 11 or 10 address bits
// - read output changes only on shift clock rising
// - dummy zero bit precedes read data
// - sequential read increments address, no dummy
// - power up leaves programming disabled
// - enable command must precede programming
// - enable holds until disable or power loss
// - disable command blocks erase and write
// - opcode 11 erases addressed word, timer starts
// - opcode 01 writes word after last bit
// - programming cycle ends within 10 ms
// - clear array command sets every bit
// - fill array command writes all words
// - busy zero, ready one after cs rises
// - no status if cycle already finished
// - reads work whether enabled or not
// - host disables programming when finished
// - width select picks 16 or 8 bits
`timescale 1ns/1ns
module twecl_device #(
  parameter int PROG_CNT = twecl_pkg::PROG_CYCLES
) (
  input  wire logic MCLK,
  input  wire logic RST_B,
  twecl_if.device   LINK,
  input  wire logic WORD_WIDTH_SELECT,
  output logic      BUSY,
  output logic      PROGRAM_ENABLED
);
  import twecl_pkg::*;

  logic         cs_s;
  logic         cs_rise;
  logic         sclk_rise;
  logic         si_s;
  logic [7:0]   mem_r [ARRAY_BYTES];
  twecl_state_t st_r;
  logic [CNT_W-1:0] cnt_r;
  logic [1:0]   op_r;
  logic [10:0]  addr_r;
  logic [15:0]  data_r;
  logic [15:0]  shout_r;
  logic         wide;
  logic         enable_r;
  logic         busy_r;
  logic [31:0]  timer_r;
  logic         so_r;
  logic         oe_r;
  logic         status_r;
  logic [CNT_W-1:0] abits;
  logic [CNT_W-1:0] dbits;
  logic [10:0]  a_next;
  logic         bit_in;
  logic         prog_go;
  logic [15:0]  rd_word;

  ////////////////////////////////////////////////////////////////////////////
  // link inputs cross into the MCLK domain
  twecl_sync u_cs (.MCLK(MCLK), .RST_B(RST_B), .D(LINK.chip_select),
                   .Q(cs_s), .RISE(cs_rise), .FALL());
  twecl_sync u_sclk (.MCLK(MCLK), .RST_B(RST_B), .D(LINK.shift_clock),
                     .Q(), .RISE(sclk_rise), .FALL());
  twecl_sync u_si (.MCLK(MCLK), .RST_B(RST_B), .D(LINK.serial_in),
                   .Q(si_s), .RISE(), .FALL());

  // organisation picks address and data widths
  assign wide  = WORD_WIDTH_SELECT;
  assign abits = wide ? CNT_W'(ADDR16_BITS) : CNT_W'(ADDR8_BITS);
  assign dbits = wide ? CNT_W'(DATA16_BITS) : CNT_W'(DATA8_BITS);
  assign bit_in = si_s;
  // next address with the shifted bit appended, msb first
  assign a_next = {addr_r[9:0], bit_in};
  // word view of the byte array; x16 word n is bytes 2n (high), 2n+1
  assign rd_word = wide ? {mem_r[{addr_r[9:0], 1'b0}],
                           mem_r[{addr_r[9:0], 1'b1}]}
                        : {8'h00, mem_r[addr_r]};

  ////////////////////////////////////////////////////////////////////////////
  // instruction sequencer
  always_ff @(posedge MCLK or negedge RST_B)
    if (!RST_B)
    begin
      st_r    <= ST_IDLE;
      cnt_r   <= '0;
      op_r    <= 2'h0;
      addr_r  <= 11'h000;
      data_r  <= 16'h0000;
      shout_r <= 16'h0000;
      prog_go <= 1'b0;
      so_r    <= 1'b0;
    end
    else
    begin
      prog_go <= 1'b0;
      if (!cs_s)
        st_r <= ST_IDLE;
      else if (cs_rise)
        st_r <= ST_IDLE;
      else if (sclk_rise)
      begin
        unique case (st_r)
          ST_IDLE:
            if (bit_in && !busy_r)
            begin
              st_r  <= ST_OP;
              cnt_r <= '0;
            end
          ST_OP:
          begin
            op_r  <= {op_r[0], bit_in};
            cnt_r <= cnt_r + 1'b1;
            if (cnt_r == CNT_W'(1))
            begin
              st_r  <= ST_ADDR;
              cnt_r <= '0;
            end
          end
          ST_ADDR:
          begin
            addr_r <= a_next;
            cnt_r  <= cnt_r + 1'b1;
            if (cnt_r == abits - 1'b1)
            begin
              cnt_r <= '0;
              if (op_r == OP_READ)
              begin
                st_r <= ST_READ;
                so_r <= 1'b0;
                cnt_r <= dbits;
              end
              else if (op_r == OP_WRITE ||
                       (op_r == OP_EXT &&
                        (wide ? addr_r[8:7] : addr_r[9:8]) == SUB_FILL))
                st_r <= ST_DATA;
              else
              begin
                st_r    <= ST_WAIT;
                prog_go <= (op_r == OP_ERASE) ||
                           ((wide ? addr_r[8:7] : addr_r[9:8]) == SUB_CLEAR);
              end
            end
          end
          ST_DATA:
          begin
            data_r <= {data_r[14:0], bit_in};
            cnt_r  <= cnt_r + 1'b1;
            if (cnt_r == dbits - 1'b1)
            begin
              st_r    <= ST_WAIT;
              prog_go <= 1'b1;
            end
          end
          ST_READ:
          begin
            // read data bits change only here, on shift clock rising
            if (cnt_r == dbits)
            begin
              so_r    <= wide ? rd_word[15] : rd_word[7];
              shout_r <= wide ? {rd_word[14:0], 1'b0}
                              : {rd_word[6:0], 9'h000};
              cnt_r   <= dbits - 1'b1;
            end
            else
            begin
              so_r    <= shout_r[15];
              shout_r <= {shout_r[14:0], 1'b0};
              cnt_r   <= cnt_r - 1'b1;
            end
            if (cnt_r == CNT_W'(1))
            begin
              addr_r <= wide ? {1'b0, addr_r[9:0] + 10'h001}
                             : addr_r + 11'h001;
              cnt_r  <= dbits;
            end
          end
          ST_WAIT:
            st_r <= ST_WAIT;
          default:
            st_r <= ST_IDLE;
        endcase
      end
    end

  ////////////////////////////////////////////////////////////////////////////
  // write-protect state, disabled from power up
  always_ff @(posedge MCLK or negedge RST_B)
    if (!RST_B)
      enable_r <= 1'b0;
    else if (sclk_rise && cs_s && st_r == ST_ADDR && op_r == OP_EXT
             && cnt_r == abits - 1'b1)
    begin
      if ((wide ? addr_r[8:7] : addr_r[9:8]) == SUB_ENABLE)
        enable_r <= 1'b1;
      else if ((wide ? addr_r[8:7] : addr_r[9:8]) == SUB_DISABLE)
        enable_r <= 1'b0;
    end

  ////////////////////////////////////////////////////////////////////////////
  // self-timed programming cycle and array update
  always_ff @(posedge MCLK or negedge RST_B)
    if (!RST_B)
    begin
      busy_r  <= 1'b0;
      timer_r <= 32'h0;
    end
    else if (prog_go && enable_r && !busy_r)
    begin
      busy_r  <= 1'b1;
      timer_r <= 32'(PROG_CNT - 1);
    end
    else if (busy_r)
    begin
      if (timer_r == 32'h0)
        busy_r <= 1'b0;
      else
        timer_r <= timer_r - 32'h1;
    end

  // array written at cycle start; ops held off until the timer ends
  always_ff @(posedge MCLK)
    if (prog_go && enable_r && !busy_r)
    begin
      for (int i = 0; i < ARRAY_BYTES; i++)
      begin
        if (op_r == OP_ERASE)
        begin
          if (wide ? (i[10:1] == addr_r[9:0]) : (i[10:0] == addr_r))
            mem_r[i] <= ERASED_BYTE;
        end
        else if (op_r == OP_WRITE)
        begin
          if (wide ? (i[10:1] == addr_r[9:0]) : (i[10:0] == addr_r))
            mem_r[i] <= wide ? (i[0] ? data_r[7:0] : data_r[15:8])
                             : data_r[7:0];
        end
        else if ((wide ? addr_r[9:8] : addr_r[10:9]) == SUB_FILL)
          mem_r[i] <= wide ? (i[0] ? data_r[7:0] : data_r[15:8])
                           : data_r[7:0];
        else
          mem_r[i] <= ERASED_BYTE;
      end
    end

  ////////////////////////////////////////////////////////////////////////////
  // status only when cs rises while a cycle is still running
  always_ff @(posedge MCLK or negedge RST_B)
    if (!RST_B)
      status_r <= 1'b0;
    else if (cs_rise)
      status_r <= busy_r;
    else if (!cs_s)
      status_r <= 1'b0;

  // output drive, released while chip select is low
  always_ff @(posedge MCLK or negedge RST_B)
    if (!RST_B)
      oe_r <= 1'b0;
    else
      oe_r <= cs_s && (st_r == ST_READ || status_r);

  assign LINK.serial_out    = status_r ? ~busy_r : so_r;
  assign LINK.serial_out_oe = oe_r;
  assign BUSY               = busy_r;
  assign PROGRAM_ENABLED    = enable_r;
endmodule : twecl_device

//--- rtl/twecl_pkg.sv
// package of constants and types for the three-wire eeprom command logic
package twecl_pkg;
  // clock and timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int PROG_TIME_MS = 10;
  localparam int PROG_CYCLES = (PROG_TIME_MS * 1000000) / CLK_PERIOD_NS;
  localparam int CS_LOW_NS = 250;
  localparam int CS_LOW_CYCLES =
    (CS_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SCLK_DIV = 8;
  // array geometry
  localparam int ARRAY_BYTES = 2048;
  localparam int ADDR8_BITS = 11;
  localparam int ADDR16_BITS = 10;
  localparam int DATA8_BITS = 8;
  localparam int DATA16_BITS = 16;
  localparam int CNT_W = 6;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  // operation codes and sub-codes
  localparam logic [1:0] OP_EXT = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_ERASE = 2'h3;
  localparam logic [1:0] SUB_DISABLE = 2'h0;
  localparam logic [1:0] SUB_FILL = 2'h1;
  localparam logic [1:0] SUB_CLEAR = 2'h2;
  localparam logic [1:0] SUB_ENABLE = 2'h3;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_OP   = 3'h1,
    ST_ADDR = 3'h2,
    ST_DATA = 3'h3,
    ST_READ = 3'h4,
    ST_WAIT = 3'h5
  } twecl_state_t;
endpackage : twecl_pkg

//--- rtl/twecl_if.sv
// interface carrying the three-wire serial link between host and device
`timescale 1ns/1ns
interface twecl_if;
  logic chip_select;
  logic shift_clock;
  logic serial_in;
  logic serial_out;
  logic serial_out_oe;
  modport device (
    input  chip_select,
    input  shift_clock,
    input  serial_in,
    output serial_out,
    output serial_out_oe
  );
  modport host (
    output chip_select,
    output shift_clock,
    output serial_in,
    input  serial_out,
    input  serial_out_oe
  );
endinterface : twecl_if

//--- rtl/twecl_sync.sv
// two flip-flop synchroniser with rising edge detect on the synchronised level
`timescale 1ns/1ns
module twecl_sync (
  input  wire logic MCLK,
  input  wire logic RST_B,
  input  wire logic D,
  output logic      Q,
  output logic      RISE,
  output logic      FALL
);
  logic meta_r;
  logic sync_r;
  logic last_r;
  // first stage read only by the second
  always_ff @(posedge MCLK or negedge RST_B)
    if (!RST_B)
    begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      last_r <= 1'b0;
    end
    else
    begin
      meta_r <= D;
      sync_r <= meta_r;
      last_r <= sync_r;
    end
  assign Q    = sync_r;
  assign RISE = sync_r & ~last_r;
  assign FALL = ~sync_r & last_r;
endmodule : twecl_sync

//--- rtl/twecl_host.sv
// host end: issues one instruction per request and reads back results
`timescale 1ns/1ns
module twecl_host (
  input  wire logic MCLK,
  input  wire logic RST_B,
  twecl_if.host     LINK,
  input  wire logic REQ_VALID,
  output logic      REQ_READY,
  input  wire logic [31:0] REQ_BITS,
  input  wire logic [5:0]  REQ_LEN,
  input  wire logic [4:0]  REQ_RD_LEN,
  output logic [15:0] RD_DATA,
  output logic      RD_VALID,
  output logic      STATUS_READY
);
  import twecl_pkg::*;

  logic        so_s;
  logic        active_r;
  logic [31:0] sh_r;
  logic [5:0]  left_r;
  logic [4:0]  rd_left_r;
  logic [2:0]  div_r;
  logic        sclk_r;
  logic        cs_r;
  logic [5:0]  gap_r;

  twecl_sync u_so (.MCLK(MCLK), .RST_B(RST_B), .D(LINK.serial_out),
                   .Q(so_s), .RISE(), .FALL());

  assign REQ_READY = !active_r && gap_r == 6'h00;

  ////////////////////////////////////////////////////////////////////////////
  // shift clock divider, bits msb first out, read bits sampled on fall
  always_ff @(posedge MCLK or negedge RST_B)
    if (!RST_B)
    begin
      active_r  <= 1'b0;
      sh_r      <= 32'h0;
      left_r    <= 6'h00;
      rd_left_r <= 5'h00;
      div_r     <= 3'h0;
      sclk_r    <= 1'b0;
      cs_r      <= 1'b0;
      gap_r     <= 6'h00;
      RD_DATA   <= 16'h0000;
      RD_VALID  <= 1'b0;
    end
    else
    begin
      RD_VALID <= 1'b0;
      if (gap_r != 6'h00)
        gap_r <= gap_r - 6'h01;
      if (REQ_VALID && REQ_READY)
      begin
        active_r  <= 1'b1;
        cs_r      <= 1'b1;
        sh_r      <= REQ_BITS;
        left_r    <= REQ_LEN;
        rd_left_r <= REQ_RD_LEN;
        div_r     <= 3'h0;
      end
      else if (active_r)
      begin
        div_r <= div_r + 3'h1;
        if (div_r == 3'(SCLK_DIV - 1))
        begin
          sclk_r <= ~sclk_r;
          if (sclk_r)
          begin
            if (left_r != 6'h00)
            begin
              sh_r   <= {sh_r[30:0], 1'b0};
              left_r <= left_r - 6'h01;
            end
            // the fall after the last sent bit already shows the dummy
            if (left_r <= 6'h01 && rd_left_r != 5'h00)
            begin
              RD_DATA   <= {RD_DATA[14:0], so_s};
              rd_left_r <= rd_left_r - 5'h01;
              RD_VALID  <= rd_left_r == 5'h01;
            end
            if (left_r <= 6'h01 && rd_left_r <= 5'h01)
            begin
              active_r <= 1'b0;
              cs_r     <= 1'b0;
              gap_r    <= 6'(CS_LOW_CYCLES + 1);
            end
          end
        end
      end
    end

  assign LINK.chip_select = cs_r;
  assign LINK.shift_clock = sclk_r;
  assign LINK.serial_in   = sh_r[31];
  assign STATUS_READY     = so_s;
endmodule : twecl_host

//--- tb/twecl_asserts.sv
// concurrent checks on the serial link and device status
`timescale 1ns/1ns
module twecl_asserts #(
  parameter int PROG_CNT = 100
) (
  input wire logic MCLK,
  input wire logic RST_B,
  input wire logic chip_select,
  input wire logic shift_clock,
  input wire logic serial_out,
  input wire logic serial_out_oe,
  input wire logic BUSY,
  input wire logic PROGRAM_ENABLED
);
  logic       sclk_d_r;
  logic [5:0] since_rise_r;
  int         busy_cnt_r;

  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RST_B);

  ////////////////////////////////////////////////////////////////////////////
  // cycles since the last shift clock rise, saturating
  always_ff @(posedge MCLK or negedge RST_B)
  begin
    if (!RST_B)
      since_rise_r <= 6'h3f;
    else if (shift_clock && !sclk_d_r)
      since_rise_r <= 6'h00;
    else if (since_rise_r != 6'h3f)
      since_rise_r <= since_rise_r + 6'h01;
  end

  // delayed shift clock for edge finding
  always_ff @(posedge MCLK or negedge RST_B)
  begin
    if (!RST_B)
      sclk_d_r <= 1'b0;
    else
      sclk_d_r <= shift_clock;
  end

  // length of the current busy period
  always_ff @(posedge MCLK or negedge RST_B)
  begin
    if (!RST_B)
      busy_cnt_r <= 0;
    else
      busy_cnt_r <= BUSY ? busy_cnt_r + 1 : 0;
  end

  // chip select held low for a while
  sequence s_cs_idle4;
    !chip_select [*4];
  endsequence
  sequence s_cs_idle8;
    !chip_select [*8];
  endsequence
  // output driven steadily after the cycle ends
  sequence s_oe_run;
    serial_out_oe [*6];
  endsequence

  AST_SK_IN_FRAME: assert property ($rose(shift_clock) |-> chip_select)
    else $error("shift clock rose outside a frame");
  AST_HIZ_CS_LOW: assert property (s_cs_idle4 |-> !serial_out_oe)
    else $error("output driven while chip select low");
  AST_OUT_ON_RISE: assert property (serial_out_oe && $past(serial_out_oe)
    && $changed(serial_out) && !BUSY && !$past(BUSY, 6)
    |-> since_rise_r <= 6'h06)
    else $error("read output changed away from a clock rise");
  AST_BUSY_LOW_OUT: assert property (BUSY && $past(BUSY, 6)
    && serial_out_oe |-> !serial_out)
    else $error("status not zero while busy");
  AST_READY_OUT: assert property ($fell(BUSY) ##0 s_oe_run
    |-> serial_out)
    else $error("status not one after cycle end");
  AST_BUSY_MAX: assert property (BUSY |-> busy_cnt_r <= PROG_CNT)
    else $error("programming cycle too long");
  AST_BUSY_MIN: assert property ($fell(BUSY)
    |-> $past(busy_cnt_r) >= PROG_CNT - 3)
    else $error("programming cycle too short");
  AST_PROG_ENABLED: assert property ($rose(BUSY) |-> PROGRAM_ENABLED)
    else $error("programming started while disabled");
  AST_EN_STABLE: assert property (s_cs_idle8 |-> $stable(PROGRAM_ENABLED))
    else $error("enable state moved without an instruction");
  AST_BUSY_START: assert property ($rose(BUSY)
    |-> since_rise_r <= 6'h06)
    else $error("cycle not started at the last bit");
endmodule : twecl_asserts

//--- tb/testbench.sv
// bench joining host and device ends over one serial link
`timescale 1ns/1ns
module testbench;
  import twecl_pkg::*;
  localparam int PCNT = 100;
  logic        MCLK;
  logic        RST_B;
  logic        req_valid;
  logic        req_ready;
  logic [31:0] req_bits;
  logic [5:0]  req_len;
  logic [4:0]  req_rd_len;
  logic [15:0] rd_data;
  logic        rd_valid;
  logic        wws;
  logic        busy;
  logic        prog_en;
  logic        status_ready;
  logic [31:0] lfsr_r;
  logic [15:0] got;
  logic [15:0] d;
  logic [10:0] a;
  int          fail_count;
  int          n_checks;

  twecl_if link ();
  twecl_device #(.PROG_CNT(PCNT)) u_twecl_device (
    .MCLK(MCLK), .RST_B(RST_B), .LINK(link),
    .WORD_WIDTH_SELECT(wws), .BUSY(busy), .PROGRAM_ENABLED(prog_en));
  twecl_host u_twecl_host (
    .MCLK(MCLK), .RST_B(RST_B), .LINK(link), .REQ_VALID(req_valid),
    .REQ_READY(req_ready), .REQ_BITS(req_bits), .REQ_LEN(req_len),
    .REQ_RD_LEN(req_rd_len), .RD_DATA(rd_data), .RD_VALID(rd_valid),
    .STATUS_READY(status_ready));
  twecl_asserts #(.PROG_CNT(PCNT)) u_twecl_asserts (
    .MCLK(MCLK), .RST_B(RST_B), .chip_select(link.chip_select),
    .shift_clock(link.shift_clock), .serial_out(link.serial_out),
    .serial_out_oe(link.serial_out_oe), .BUSY(busy),
    .PROGRAM_ENABLED(prog_en));

  ////////////////////////////////////////////////////////////////////////////
  // next value of the stimulus shift register
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  // address field of an extended command for the current width
  function automatic logic [10:0] ext(input logic [1:0] sub);
    return wws ? {1'b0, sub, 8'h00} : {sub, 9'h000};
  endfunction : ext

  // counts, verdict, stop
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run

  // compare seen against expected
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // bounded wait for ready, read valid or busy to reach a level
  task automatic wt(input int k, input logic lvl);
    for (int i = 0; i < 4000; i++)
    begin
      @(posedge MCLK);
      if ((k == 0 ? req_ready : k == 1 ? rd_valid : busy) === lvl)
        return;
    end
    fail_count++;
    complete_run();
  endtask : wt

  // one instruction: lead bit, opcode, address, data, msb first
  task automatic send(input logic [1:0] op, input logic [10:0] adr,
    input logic [15:0] dat, input int nd, input int rd, input bit prog);
    int na;
    na = wws ? 10 : 11;
    req_bits <= {1'b1, op, 29'h0} | ({21'h0, adr} << (29 - na))
      | ({16'h0, dat} << (29 - na - nd));
    req_len <= 6'(3 + na + nd);
    req_rd_len <= 5'(rd);
    req_valid <= 1'b1;
    wt(0, 1'b1);
    @(negedge MCLK);
    req_valid <= 1'b0;
    if (rd > 0)
    begin
      wt(1, 1'b1);
      got = rd_data;
    end
    if (prog)
    begin
      wt(2, 1'b1);
      wt(2, 1'b0);
    end
    wt(0, 1'b1);
    @(negedge MCLK);
  endtask : send

  // status frame: lead bit never set, chip select held for twelve shift clocks
  task automatic poll(input bit live);
    req_bits <= 32'h0;
    req_len <= 6'h0c;
    req_rd_len <= 5'h00;
    req_valid <= 1'b1;
    wt(0, 1'b1);
    @(negedge MCLK);
    req_valid <= 1'b0;
    repeat (8) @(negedge MCLK);
    chk({15'h0, link.serial_out_oe}, {15'h0, live});
    if (live)
    begin
      chk({15'h0, status_ready}, 16'h0000);
      wt(2, 1'b0);
      repeat (8) @(negedge MCLK);
      chk({15'h0, status_ready}, 16'h0001);
    end
    wt(0, 1'b1);
    @(negedge MCLK);
  endtask : poll

  // clock
  initial
  begin
    MCLK = 1'b0;
    forever #4 MCLK = ~MCLK;
  end

  // main sequence
  initial
  begin
    RST_B = 1'b0;
    req_valid = 1'b0;
    req_bits = '0;
    req_len = '0;
    req_rd_len = '0;
    wws = 1'b1;
    lfsr_r = 32'hf8ea;
    fail_count = 0;
    n_checks = 0;
    got = '0;
    repeat (12) @(negedge MCLK);
    RST_B = 1'b1;
    @(negedge MCLK);
    chk({15'h0, prog_en}, 16'h0001 ^ 16'h0001);
    send(OP_WRITE, 11'h005, 16'h1234, 16, 0, 0);
    chk({15'h0, busy}, 16'h0000);
    send(OP_EXT, ext(SUB_ENABLE), 16'h0, 0, 0, 0);
    chk({15'h0, prog_en}, 16'h0001);
    send(OP_EXT, ext(SUB_CLEAR), 16'h0, 0, 0, 1);
    send(OP_READ, 11'h005, 16'h0, 0, 17, 0);
    chk(got, 16'hffff);
    repeat (4)
    begin
      lfsr_r = lfsr_next(lfsr_r);
      a = lfsr_r[10:0] & 11'h3ff;
      d = lfsr_r[31:16];
      send(OP_WRITE, a, d, 16, 0, 1);
      send(OP_READ, a, 16'h0, 0, 17, 0);
      chk(got, d);
      send(OP_ERASE, a, 16'h0, 0, 0, 1);
      send(OP_READ, a, 16'h0, 0, 17, 0);
      chk(got, 16'hffff);
    end
    send(OP_WRITE, 11'h011, ~d, 16, 0, 0);
    poll(1'b1);
    poll(1'b0);
    send(OP_READ, 11'h011, 16'h0, 0, 17, 0);
    chk(got, ~d);
    send(OP_EXT, ext(SUB_FILL), d, 16, 0, 1);
    send(OP_READ, 11'h000, 16'h0, 0, 17, 0);
    chk(got, d);
    send(OP_READ, 11'h3ff, 16'h0, 0, 17, 0);
    chk(got, d);
    chk({15'h0, prog_en}, 16'h0001);
    send(OP_EXT, ext(SUB_DISABLE), 16'h0, 0, 0, 0);
    chk({15'h0, prog_en}, 16'h0000);
    send(OP_ERASE, 11'h3ff, 16'h0, 0, 0, 0);
    send(OP_READ, 11'h3ff, 16'h0, 0, 17, 0);
    chk(got, d);
    wws = 1'b0;
    send(OP_EXT, ext(SUB_ENABLE), 16'h0, 0, 0, 0);
    send(OP_WRITE, 11'h7fe, 16'h005a, 8, 0, 1);
    send(OP_WRITE, 11'h7ff, 16'h00c3, 8, 0, 1);
    send(OP_READ, 11'h7fe, 16'h0, 0, 17, 0);
    chk(got, 16'h5ac3);
    wws = 1'b1;
    send(OP_READ, 11'h3ff, 16'h0, 0, 17, 0);
    chk(got, 16'h5ac3);
    send(OP_EXT, ext(SUB_DISABLE), 16'h0, 0, 0, 0);
    complete_run();
  end
endmodule : testbench
